// *** logic/rsc_reset_state_controller.v ***
// Reset state controller: holds the core in reset and sets release defaults
`timescale 1ns/1ps
`default_nettype none
`include "rsc_defs.vh"

// Summary of operation
// - Reset halts execution, disables interrupts and timers
// - Reset loads register defaults
// - Reset never touches RAM; stack pointer reinitialised
// - Port latches all ones, open-drain during reset
// - Port weak pull-ups on during and after reset
// - Power-on reset: reset pin undriven, pull-up off
// - Supply monitor reset drives reset pin low
// - Release clears PC, selects internal oscillator
// - Release enables watchdog at clock divided by twelve
// - Fetch begins at address zero after reset
// - Power-on sets flag; other resets clear it
// - Power-on/power-fail enable and select supply monitor
// - Monitor disabled: any reset becomes power-on reset
module rsc_reset_state_controller
(
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire        i_por_req,
  input  wire        i_supply_fail,
  input  wire        i_ext_rst_n,
  input  wire        i_other_rst,
  input  wire        i_mon_disable_wr,
  input  wire        i_mon_disable_val,
  input  wire        i_mon_select_wr,
  input  wire        i_mon_select_val,
  output reg         o_core_halt,
  output reg         o_regs_load_default,
  output reg         o_irq_enable,
  output reg         o_timers_enable,
  output reg         o_sp_reinit,
  output wire        o_ram_write_block,
  output reg  [7:0]  o_port_latch,
  output reg         o_port_open_drain,
  output reg         o_port_pullup_en,
  output reg         o_rst_pin_out,
  output reg         o_rst_pin_oe,
  output reg         o_rst_pin_pullup_en,
  output reg  [15:0] o_pc,
  output reg  [1:0]  o_clk_select,
  output reg         o_wdt_enable,
  output reg         o_wdt_tick,
  output reg         o_power_on_reset_flag,
  output reg         o_supply_monitor_disable,
  output reg         o_supply_monitor_select
);

  // ****************************************
  // Pin and source synchronisers
  // ****************************************
  // Bit order: power-on, supply fail, pin (made active high), other
  wire [3:0] raw_src = {i_other_rst, ~i_ext_rst_n, i_supply_fail, i_por_req};
  wire [3:0] sync_out;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      reg sync1_reg;
      reg sync2_reg;

      // Two stages: every source is asynchronous to the core clock
      always @(posedge i_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          sync1_reg <= 1'b0;
          sync2_reg <= 1'b0;
        end
        else if (i_ce)
        begin
          sync1_reg <= raw_src[gi];
          sync2_reg <= sync1_reg;
        end
      end

      assign sync_out[gi] = sync2_reg;
    end
  endgenerate

  wire por_s    = sync_out[0];
  wire supply_s = sync_out[1] & o_supply_monitor_select & ~o_supply_monitor_disable;
  wire other_s  = sync_out[2] | sync_out[3];
  wire any_src  = por_s | supply_s | other_s;

  // Disabled monitor means pin and other sources are promoted to power-on; supply fail is masked
  wire is_por   = por_s | (o_supply_monitor_disable & any_src);

  // ****************************************
  // Reset state and source capture
  // ****************************************
  reg        in_reset_reg;
  reg [1:0]  cause_reg;
  reg [1:0]  cause_next;
  reg [3:0]  wdt_div_reg;

  always @*
  begin
    cause_next = cause_reg;
    // Power-on outranks supply fail, which outranks the pin and others
    // A weaker source never downgrades a cause already held
    if (is_por)
      cause_next = `RSC_SRC_POR;
    else if (supply_s && cause_reg != `RSC_SRC_POR)
      cause_next = `RSC_SRC_SUPPLY;
    else if (other_s && cause_reg == `RSC_SRC_NONE)
      cause_next = `RSC_SRC_OTHER;
  end

  // RAM has no reset path here; only writes are blocked during reset
  assign o_ram_write_block = in_reset_reg;

  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      in_reset_reg             <= 1'b1;
      cause_reg                <= `RSC_SRC_POR;
      wdt_div_reg              <= 4'h0;
      o_core_halt              <= 1'b1;
      o_regs_load_default      <= 1'b1;
      o_irq_enable             <= 1'b0;
      o_timers_enable          <= 1'b0;
      o_sp_reinit              <= 1'b1;
      o_port_latch             <= `RSC_PORT_LATCH_RST;
      o_port_open_drain        <= 1'b1;
      o_port_pullup_en         <= 1'b1;
      o_rst_pin_out            <= 1'b0;
      o_rst_pin_oe             <= 1'b0;
      o_rst_pin_pullup_en      <= 1'b0;
      o_pc                     <= `RSC_PC_RST;
      o_clk_select             <= `RSC_CLKSEL_INTERNAL;
      o_wdt_enable             <= 1'b0;
      o_wdt_tick               <= 1'b0;
      o_power_on_reset_flag    <= 1'b0;
      o_supply_monitor_disable <= 1'b0;
      o_supply_monitor_select  <= 1'b1;
    end
    else if (i_ce)
    begin
      o_wdt_tick <= 1'b0;
      if (any_src || (in_reset_reg && cause_reg != `RSC_SRC_NONE && any_src))
      begin
        // Held while any source stays asserted
        in_reset_reg        <= 1'b1;
        cause_reg           <= cause_next;
        o_core_halt         <= 1'b1;
        o_irq_enable        <= 1'b0;
        o_timers_enable     <= 1'b0;
        o_regs_load_default <= 1'b1;
        o_sp_reinit         <= 1'b1;
        o_port_latch        <= `RSC_PORT_LATCH_RST;
        o_port_open_drain   <= 1'b1;
        o_port_pullup_en    <= 1'b1;
        o_wdt_enable        <= 1'b0;
        wdt_div_reg         <= 4'h0;
        if (cause_next == `RSC_SRC_POR)
        begin
          o_rst_pin_oe        <= 1'b0;
          o_rst_pin_pullup_en <= 1'b0;
        end
        else if (cause_next == `RSC_SRC_SUPPLY)
        begin
          // Open-drain pin: only ever pulled low, never driven high
          o_rst_pin_oe        <= 1'b1;
          o_rst_pin_out       <= 1'b0;
          o_rst_pin_pullup_en <= 1'b0;
        end
        else
        begin
          o_rst_pin_oe        <= 1'b0;
          o_rst_pin_pullup_en <= 1'b1;
        end
      end
      else if (in_reset_reg)
      begin
        // Release on the clock once every source is quiet
        in_reset_reg        <= 1'b0;
        cause_reg           <= `RSC_SRC_NONE;
        o_core_halt         <= 1'b0;
        o_regs_load_default <= 1'b0;
        o_sp_reinit         <= 1'b0;
        o_port_pullup_en    <= 1'b1;
        o_rst_pin_oe        <= 1'b0;
        o_rst_pin_pullup_en <= 1'b1;
        o_pc                <= `RSC_PC_RST;
        o_clk_select        <= `RSC_CLKSEL_INTERNAL;
        o_wdt_enable        <= 1'b1;
        o_power_on_reset_flag <= (cause_reg == `RSC_SRC_POR);
        if (cause_reg == `RSC_SRC_POR || cause_reg == `RSC_SRC_SUPPLY)
        begin
          o_supply_monitor_disable <= 1'b0;
          o_supply_monitor_select  <= 1'b1;
        end
      end
      else
      begin
        // Watchdog time base: system clock divided by twelve
        // First tick lands twelve clocks after release
        if (wdt_div_reg == `RSC_WDT_DIV_LAST)
        begin
          wdt_div_reg <= 4'h0;
          o_wdt_tick  <= o_wdt_enable;
        end
        else
          wdt_div_reg <= wdt_div_reg + 4'h1;
        // Software control of monitor only outside reset
        if (i_mon_disable_wr)
          o_supply_monitor_disable <= i_mon_disable_val;
        if (i_mon_select_wr)
          o_supply_monitor_select <= i_mon_select_val;
      end
    end
  end

endmodule
`default_nettype wire

// *** logic/rsc_defs.vh ***
// Constants for the reset state controller
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_PORT_LATCH_RST  8'hFF
`define RSC_PC_RST          16'h0000
`define RSC_WDT_DIV         4'hC
`define RSC_WDT_DIV_LAST    4'hB
`define RSC_CLKSEL_INTERNAL 2'h0
`define RSC_SRC_NONE        2'h0
`define RSC_SRC_POR         2'h1
`define RSC_SRC_SUPPLY      2'h2
`define RSC_SRC_OTHER       2'h3
`endif

// *** tb/rsc_chk_sva.sv ***
// Checker for the reset state controller
`timescale 1ns/1ps
`default_nettype none
module rsc_chk (
  input wire       i_clk, i_rst, i_ce, i_other_rst, o_core_halt, o_regs_load_default,
  input wire       o_irq_enable, o_timers_enable, o_sp_reinit, o_ram_write_block,
  input wire       o_port_open_drain, o_port_pullup_en, o_rst_pin_out, o_rst_pin_oe,
  input wire       o_rst_pin_pullup_en, o_wdt_enable, o_wdt_tick,
  input wire [7:0] o_port_latch,
  input wire [15:0] o_pc,
  input wire [1:0] o_clk_select
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire rs = o_ram_write_block;
  a_core_stop: assert property (rs |-> o_core_halt && !o_irq_enable && !o_timers_enable)
    else $error("core runs in reset");
  a_regs_default: assert property (rs |-> o_regs_load_default && o_sp_reinit)
    else $error("defaults off");
  a_port_safe: assert property (rs |-> o_port_latch == 8'hFF && o_port_open_drain)
    else $error("port state");
  a_pullup_on: assert property (o_port_pullup_en)
    else $error("pull-up off");
  a_pin_drive: assert property (o_rst_pin_oe |-> rs && !o_rst_pin_out && !o_rst_pin_pullup_en)
    else $error("pin drive");
  a_exit_state: assert property ($fell(rs) |-> !o_pc && !o_clk_select && o_wdt_enable)
    else $error("exit state");
  a_wdt_period: assert property (disable iff (i_rst || rs || !i_ce)
    o_wdt_tick |=> !o_wdt_tick [*8] ##1 !o_wdt_tick [*3] ##1 o_wdt_tick) else $error("tick");
  a_enter_reset: assert property (i_other_rst |-> ##[1:3] rs)
    else $error("no entry");
  cover property ($fell(rs));
  cover property (o_rst_pin_oe);
  cover property (o_wdt_tick);
endmodule
`default_nettype wire

// *** tb/rsc_src_model.sv ***
// Reset source model: power-on detector, supply monitor, pin and other source
`timescale 1ns/1ps
`default_nettype none
module rsc_src_model (
  input  wire       i_clk,
  input  wire       i_go,
  input  wire [1:0] i_kind,
  input  wire [3:0] i_len,
  output wire       o_por_req,
  output wire       o_supply_fail,
  output wire       o_ext_rst_n,
  output wire       o_other_rst
);
  reg [5:0] st_reg = 6'h0;
  always @(posedge i_clk)
    if (i_go)
      st_reg <= {i_len, i_kind};
    else if (st_reg[5:2] != 4'h0)
      st_reg[5:2] <= st_reg[5:2] - 4'h1;
  wire on = st_reg[5:2] != 4'h0;
  assign o_por_req = on && st_reg[1:0] == 2'h0;
  assign o_supply_fail = on && st_reg[1:0] == 2'h1;
  // Pin idles high through its pull-up
  assign o_ext_rst_n = !(on && st_reg[1:0] == 2'h2);
  assign o_other_rst = on && st_reg[1:0] == 2'h3;
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking testbench for the reset state controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module testbench;
  logic i_clk = 1'b0, i_rst = 1'b1, go = 1'b0, hit, por, dis = 1'b0, sel = 1'b1;
  logic i_ce = 1'b1;
  logic i_mon_disable_wr = 1'b0, i_mon_disable_val = 1'b0;
  logic i_mon_select_wr = 1'b0, i_mon_select_val = 1'b0;
  logic [1:0] kind = 2'h0;
  logic [3:0] len = 4'h1;
  wire [15:0] o_pc;
  wire [7:0] o_port_latch;
  wire [1:0] o_clk_select;
  wire i_por_req, i_supply_fail, i_ext_rst_n, i_other_rst, o_core_halt;
  wire o_regs_load_default, o_irq_enable, o_timers_enable, o_sp_reinit, o_ram_write_block;
  wire o_port_open_drain, o_port_pullup_en, o_rst_pin_out, o_rst_pin_oe, o_rst_pin_pullup_en;
  wire o_wdt_enable, o_wdt_tick, o_power_on_reset_flag, o_supply_monitor_disable;
  wire o_supply_monitor_select;
  wire [2:0] st = {o_power_on_reset_flag, o_supply_monitor_disable, o_supply_monitor_select};
  integer bad_count = 0, n_checks = 0, seed = 32'hB256, w, i;
  rsc_reset_state_controller u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
    .i_por_req(i_por_req), .i_supply_fail(i_supply_fail), .i_ext_rst_n(i_ext_rst_n),
    .i_other_rst(i_other_rst), .i_mon_disable_wr(i_mon_disable_wr),
    .i_mon_disable_val(i_mon_disable_val), .i_mon_select_wr(i_mon_select_wr),
    .i_mon_select_val(i_mon_select_val), .o_core_halt(o_core_halt),
    .o_regs_load_default(o_regs_load_default), .o_irq_enable(o_irq_enable),
    .o_timers_enable(o_timers_enable), .o_sp_reinit(o_sp_reinit),
    .o_ram_write_block(o_ram_write_block), .o_port_latch(o_port_latch),
    .o_port_open_drain(o_port_open_drain), .o_port_pullup_en(o_port_pullup_en),
    .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe(o_rst_pin_oe),
    .o_rst_pin_pullup_en(o_rst_pin_pullup_en), .o_pc(o_pc), .o_clk_select(o_clk_select),
    .o_wdt_enable(o_wdt_enable), .o_wdt_tick(o_wdt_tick),
    .o_power_on_reset_flag(o_power_on_reset_flag),
    .o_supply_monitor_disable(o_supply_monitor_disable),
    .o_supply_monitor_select(o_supply_monitor_select));
  rsc_src_model u_src (.i_clk(i_clk), .i_go(go), .i_kind(kind), .i_len(len),
    .o_por_req(i_por_req), .o_supply_fail(i_supply_fail), .o_ext_rst_n(i_ext_rst_n),
    .o_other_rst(i_other_rst));
  // No external memory in this bench, so nothing lives at address zero
  // Pin drive and pull-up for a given cause
  function automatic logic [1:0] exp_pin(input logic [1:0] k, input logic p);
    exp_pin = p ? 2'h0 : (k == 2'h1 ? 2'h2 : 2'h1);
  endfunction
  task stop_test;
    $display("errors %0d checks %0d", bad_count, n_checks);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial forever #5 i_clk = ~i_clk;
  initial
  begin
    #300000 bad_count++;
    stop_test;
  end
  initial
  begin
    repeat (6) @(posedge i_clk);
    #1 i_rst = 1'b0;
    #30 `CHK({st, o_ram_write_block, o_wdt_enable}, 5'h15)
    repeat (60)
    begin
      w = $random(seed);
      {i_mon_disable_wr, i_mon_disable_val} = {w[2], w[3] & w[10]};
      {i_mon_select_wr, i_mon_select_val} = w[5:4];
      #10 {i_mon_disable_wr, i_mon_select_wr} = 2'h0;
      if (w[2]) dis = w[3] & w[10];
      if (w[5]) sel = w[4];
      {go, kind, len} = {1'b1, w[1:0], w[9:6] | 4'h1};
      #10 go = 1'b0;
      // Supply fault is refused while the monitor is off or not selected
      hit = !(kind == 2'h1 && (dis || !sel));
      por = kind == 2'h0 || dis;
      for (i = 0; i < 12 && o_ram_write_block !== 1'b1; i++) #10;
      `CHK(o_ram_write_block, hit)
      if (hit)
      begin
        `CHK({o_rst_pin_oe, o_rst_pin_pullup_en}, exp_pin(kind, por))
        for (i = 0; i < 40 && o_ram_write_block !== 1'b0; i++) #10;
        if (por || kind == 2'h1) {dis, sel} = 2'h1;
        `CHK(st, {por, dis, sel})
      end
      #200;
    end
    // Clock enable low freezes state: a monitor write is lost, tick holds
    i_ce = 1'b0;
    w = o_wdt_tick;
    {i_mon_disable_wr, i_mon_disable_val} = 2'h3;
    #10 i_mon_disable_wr = 1'b0;
    #150 `CHK({st[1:0], o_wdt_tick}, {dis, sel, w[0]})
    i_ce = 1'b1;
    // Mid-run reset is a power-on reset: monitor back on and selected
    #10 {i_mon_disable_wr, i_mon_disable_val} = 2'h3;
    #10 i_mon_disable_wr = 1'b0;
    `CHK(st[1:0], {1'b1, sel})
    i_rst = 1'b1;
    #20 i_rst = 1'b0;
    #30 `CHK({st, o_ram_write_block, o_wdt_enable}, 5'h15)
    stop_test;
  end
endmodule
bind rsc_reset_state_controller rsc_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_other_rst(i_other_rst), .o_core_halt(o_core_halt),
  .o_regs_load_default(o_regs_load_default), .o_irq_enable(o_irq_enable),
  .o_timers_enable(o_timers_enable), .o_sp_reinit(o_sp_reinit),
  .o_ram_write_block(o_ram_write_block), .o_port_open_drain(o_port_open_drain),
  .o_port_pullup_en(o_port_pullup_en), .o_rst_pin_out(o_rst_pin_out),
  .o_rst_pin_oe(o_rst_pin_oe), .o_rst_pin_pullup_en(o_rst_pin_pullup_en),
  .o_wdt_enable(o_wdt_enable), .o_wdt_tick(o_wdt_tick), .o_port_latch(o_port_latch),
  .o_pc(o_pc), .o_clk_select(o_clk_select));
`default_nettype wire
